// *** design/csf_defines.svh ***
/*
  constants of the processor status flag register: bit positions,
  reset values and the register's word indices on the register bus.
  assumes it is included by its bare name, after the package.
*/
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH

`define CSF_BIT_C       0
`define CSF_BIT_HC      1
`define CSF_BIT_Z       2
`define CSF_BIT_PWRDN   3
`define CSF_BIT_WDEXP   4
`define CSF_BIT_BANK_LO 5
`define CSF_BIT_BANK_HI 6
`define CSF_BIT_IND     7
`define CSF_RST_STAT    8'h18
`define CSF_IDX_LO      12'h003
`define CSF_IDX_HI      12'h083
`define CSF_BANK_SHIFT  7
`define CSF_BANK_SPAN   9'h080

`endif

// *** design/csf_pkg.sv ***
/*
  types of the processor status flag register.
  assumes a single core clock domain.
*/
`default_nettype none

package csf_pkg;

  // destination write from the execution unit
  typedef struct packed {
    logic       wr;
    logic       clr;
    logic [2:0] upd;
    logic [7:0] data;
  } csf_fwr_t;

  // raw outcome of the alu for the current instruction
  typedef struct packed {
    logic [7:0] result;
    logic       carry;
    logic       digit_carry;
    logic       is_sub;
  } csf_alu_t;

endpackage

`default_nettype wire

// *** design/csf_status_reg.sv ***
/*
  8-bit processor status register with masked writes, alu flag update,
  reset-cause tracking and an apb read/write window for software.
  assumes the execution unit and the alu sit on the same clock, and that
  the apb master follows the usual setup and access phases.
*/
`include "csf_defines.svh"
`default_nettype none

// How it works
// RULE1: flags, reset causes, bank bits share one register
// RULE2: status accepted as any instruction's destination
// RULE3: flag-updating write keeps alu flags, not data
// RULE4: software writes never touch reset-cause flags
// RULE5: clear zeroes bank bits, sets zero flag
// RULE6: software should prefer flag-neutral ops
// RULE7: software keeps bits 7 and 6 zero
// RULE8: upper bank bits not general storage
// RULE9: subtraction flags carry as inverted borrows
// RULE10: bank field selects 128-byte address window
// RULE11: watchdog flag set by power-up, clear, sleep
// RULE12: zero flag follows result equal zero
// RULE13: half carry from bit three carry out
// RULE14: power-down flag set power-up, cleared sleep
module csf_status_reg
  import csf_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire csf_pkg::csf_fwr_t i_fwr,
  input  wire csf_pkg::csf_alu_t i_alu,
  input  wire logic              i_watchdog_clear_op,
  input  wire logic              i_sleep_op,
  input  wire logic              i_watchdog_timeout,
  output logic      [7:0]        o_status,
  output logic      [8:0]        o_bank_base
);
  import csf_pkg::*;

  // the alias window needs twelve address bits
  if (ADDR_W < 12)
  begin : g_addr_w_chk
    $error("csf_status_reg: ADDR_W must be at least 12");
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, so pready always comes from a flop

  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic       pready_r;
  logic       hit;
  logic       apb_done;
  logic       sw_wr;

  assign hit      = (i_paddr == ADDR_W'({`CSF_IDX_LO, 2'b00})) ||
                    (i_paddr == ADDR_W'({`CSF_IDX_HI, 2'b00}));
  assign apb_done = i_psel && i_penable && pready_r;
  assign sw_wr    = apb_done && i_pwrite && hit && !i_fwr.wr && !i_fwr.clr;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      pready_r <= 1'b0;
    else
      pready_r <= i_psel && i_penable && !pready_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (i_psel && i_penable && !pready_r)
    begin
      o_prdata  <= (hit && !i_pwrite) ? {24'h00_0000, stat_nxt} : 32'h0000_0000;
      o_pslverr <= !hit;
    end
  end

  assign o_pready = pready_r;

  ////////////////////////////////////////////////////////////////////////
  // next value of the status byte

  logic z_new;
  logic hc_new;
  logic c_new;

  always_comb
  begin
    z_new  = (i_alu.result == 8'h00);                          // RULE12
    hc_new = i_alu.is_sub ? !i_alu.digit_carry : i_alu.digit_carry; // RULE9 RULE13
    c_new  = i_alu.is_sub ? !i_alu.carry : i_alu.carry;        // RULE9
  end

  always_comb
  begin
    stat_nxt = stat_r;
    // destination write: every bit but the reset causes
    if (i_fwr.clr)
    begin
      stat_nxt[`CSF_BIT_IND:`CSF_BIT_BANK_LO] = 3'b000;         // RULE5
      stat_nxt[`CSF_BIT_Z]                    = 1'b1;           // RULE5
    end
    else if (i_fwr.wr)
    begin
      stat_nxt[`CSF_BIT_IND:`CSF_BIT_BANK_LO] = i_fwr.data[`CSF_BIT_IND:`CSF_BIT_BANK_LO]; // RULE2
      stat_nxt[`CSF_BIT_Z:`CSF_BIT_C]         = i_fwr.data[`CSF_BIT_Z:`CSF_BIT_C];         // RULE2
    end
    else if (sw_wr)
    begin
      stat_nxt[`CSF_BIT_IND:`CSF_BIT_BANK_LO] = i_pwdata[`CSF_BIT_IND:`CSF_BIT_BANK_LO];   // RULE4
      stat_nxt[`CSF_BIT_Z:`CSF_BIT_C]         = i_pwdata[`CSF_BIT_Z:`CSF_BIT_C];           // RULE4
    end
    // alu flags override the data write for the bits the op updates
    if (!i_fwr.clr)
    begin
      if (i_fwr.upd[`CSF_BIT_C])
        stat_nxt[`CSF_BIT_C] = c_new;                           // RULE3
      if (i_fwr.upd[`CSF_BIT_HC])
        stat_nxt[`CSF_BIT_HC] = hc_new;                         // RULE3
      if (i_fwr.upd[`CSF_BIT_Z])
        stat_nxt[`CSF_BIT_Z] = z_new;                           // RULE3
    end
    // reset causes change only through device events
    if (i_watchdog_clear_op)
    begin
      stat_nxt[`CSF_BIT_WDEXP] = 1'b1;                          // RULE11
      stat_nxt[`CSF_BIT_PWRDN] = 1'b1;                          // RULE14
    end
    if (i_sleep_op)
    begin
      stat_nxt[`CSF_BIT_WDEXP] = 1'b1;                          // RULE11
      stat_nxt[`CSF_BIT_PWRDN] = 1'b0;                          // RULE14
    end
    // a time-out is the rarer cause, so it must not be masked by a clear
    if (i_watchdog_timeout)
      stat_nxt[`CSF_BIT_WDEXP] = 1'b0;                          // RULE11
  end

  ////////////////////////////////////////////////////////////////////////
  // the register and its bank decode

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      stat_r <= `CSF_RST_STAT;                                  // RULE1 RULE11 RULE14
    else
      stat_r <= stat_nxt;                                       // RULE1
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_bank_base <= 9'h000;
    else
      o_bank_base <= {stat_nxt[`CSF_BIT_BANK_HI:`CSF_BIT_BANK_LO], {`CSF_BANK_SHIFT{1'b0}}}; // RULE10
  end

  assign o_status = stat_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sw_no_cause_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE4
    (sw_wr && !i_watchdog_clear_op && !i_sleep_op && !i_watchdog_timeout)
      |=> o_status[`CSF_BIT_WDEXP:`CSF_BIT_PWRDN] == $past(stat_r[`CSF_BIT_WDEXP:`CSF_BIT_PWRDN]))
    else $error("software write changed a reset-cause flag");

  clear_file_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE5
    (i_fwr.clr && !i_watchdog_clear_op && !i_sleep_op && !i_watchdog_timeout)
      |=> o_status[`CSF_BIT_IND:`CSF_BIT_BANK_LO] == 3'b000 && o_status[`CSF_BIT_Z]
          && o_status[`CSF_BIT_WDEXP:`CSF_BIT_PWRDN] == $past(stat_r[`CSF_BIT_WDEXP:`CSF_BIT_PWRDN])
          && o_status[`CSF_BIT_HC:`CSF_BIT_C] == $past(stat_r[`CSF_BIT_HC:`CSF_BIT_C]))
    else $error("clear of status gave wrong pattern");

  masked_zero_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE3
    (i_fwr.wr && !i_fwr.clr && i_fwr.upd[`CSF_BIT_Z])
      |=> o_status[`CSF_BIT_Z] == ($past(i_alu.result) == 8'h00))
    else $error("zero flag took data instead of alu outcome");

  sub_carry_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE9
    (!i_fwr.clr && i_fwr.upd[`CSF_BIT_C] && i_alu.is_sub)
      |=> o_status[`CSF_BIT_C] == !$past(i_alu.carry))
    else $error("subtraction carry is not an inverted borrow");

  half_carry_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE13
    (!i_fwr.clr && i_fwr.upd[`CSF_BIT_HC])
      |=> o_status[`CSF_BIT_HC] == ($past(i_alu.digit_carry) ^ $past(i_alu.is_sub)))
    else $error("half carry flag wrong");

  sleep_flags_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE14
    (i_sleep_op && !i_watchdog_timeout) |=> !o_status[`CSF_BIT_PWRDN] && o_status[`CSF_BIT_WDEXP])
    else $error("sleep did not set reset-cause flags");

  timeout_flag_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE11
    i_watchdog_timeout |=> !o_status[`CSF_BIT_WDEXP])
    else $error("time-out did not clear watchdog flag");

  // checked as bank number times bank span, not by the shift the logic uses
  bank_map_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE10
    o_bank_base == {7'h00, o_status[`CSF_BIT_BANK_HI:`CSF_BIT_BANK_LO]} * `CSF_BANK_SPAN)
    else $error("bank base disagrees with bank bits");

  apb_wait_a: assert property (@(posedge i_clk) disable iff (i_reset) // apb one wait state
    (i_psel && i_penable && !o_pready) |=> o_pready)
    else $error("apb access not answered after one wait");

endmodule

`default_nettype wire

// *** tb/csf_exec_model.sv ***
/*
  execution unit and alu model that feeds the status register's flag ports.
  assumes the bench calls run() from one thread, one operation at a time.
*/
`default_nettype none
module csf_exec_model
  import csf_pkg::*;
(
  input  wire logic              i_clk,
  output var  csf_pkg::csf_fwr_t o_fwr,
  output var  csf_pkg::csf_alu_t o_alu,
  output var  logic [2:0]        o_evt
);
  initial
  begin
    o_fwr = '0;
    o_alu = '0;
    o_evt = 3'h0;
  end
  // op: 2 move to status, 3 add into status, 4 subtract, 5 add, 6 clear, 7 events {clr,timeout,sleep}
  task automatic run(input logic [2:0] op, input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    logic [4:0] h;
    logic       sub;
    begin
      sub = (op == 3'h4);
      s = sub ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
      h = sub ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
      @(posedge i_clk);
      o_alu <= {s[7:0], s[8], h[4], sub};
      o_fwr <= {op == 3'h2 || op == 3'h3, op == 3'h6, (op >= 3'h3 && op <= 3'h5) ? 3'h7 : 3'h0,
                op == 3'h3 ? s[7:0] : x};
      o_evt <= (op == 3'h7) ? x[2:0] : 3'h0;
      @(posedge i_clk);
      // unqualified alu lines toggle so a design that ignores upd shows it
      o_alu <= ~o_alu;
      o_fwr <= '0;
      o_evt <= 3'h0;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/csf_status_reg_test.sv ***
/*
  self-checking bench of the status register: reset, then table of operations,
  unmapped access and mid-run reset. assumes a 100 MHz core clock.
*/
`default_nettype none
module csf_status_reg_test;
  timeunit 1ns;
  timeprecision 1ps;
  import csf_pkg::*;
  typedef struct packed {logic [2:0] op; logic [7:0] x; logic [7:0] y; logic [7:0] e;} csf_row_t;
  logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  status;
  logic [8:0]  bank;
  logic [2:0]  evt;
  csf_fwr_t    fwr;
  csf_alu_t    alu;
  int failures = 0;
  int checks = 0;
  // op 0 apb write, 1 apb read through the alias, others go to the execution model
  csf_row_t rows[12] = '{
    {3'h0, 8'h27, 8'h00, 8'h3f},
    {3'h1, 8'h00, 8'h00, 8'h3f},
    {3'h3, 8'h0f, 8'hf5, 8'h1b},
    {3'h4, 8'h05, 8'h05, 8'h1f},
    {3'h4, 8'h10, 8'h01, 8'h19},
    {3'h5, 8'hff, 8'h01, 8'h1f},
    {3'h2, 8'h23, 8'h00, 8'h3b},
    {3'h6, 8'h00, 8'h00, 8'h1f},
    {3'h7, 8'h01, 8'h00, 8'h17},
    {3'h7, 8'h02, 8'h00, 8'h07},
    {3'h7, 8'h04, 8'h00, 8'h1f},
    {3'h7, 8'h07, 8'h00, 8'h07}};
  csf_status_reg #(.ADDR_W(12)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_fwr(fwr), .i_alu(alu), .i_watchdog_clear_op(evt[2]), .i_sleep_op(evt[0]),
    .i_watchdog_timeout(evt[1]), .o_status(status), .o_bank_base(bank));
  csf_exec_model exec_u (.i_clk(i_clk), .o_fwr(fwr), .o_alu(alu), .o_evt(evt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic se);
    begin
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      // read before the slave's flops move, so this is what the edge samples; the watchdog bounds the wait
      do
      begin
        @(posedge i_clk);
      end
      while (pready !== 1'b1);
      r = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    #100000;
    failures++;
    close_out();
  end
  initial
  begin
    i_reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    chk("reset status", status, 8'h18);
    chk("reset bank", bank, 9'h000);
    foreach (rows[i])
    begin
      if (rows[i].op == 3'h0)
        apb(1'b1, 12'h00c, {24'h0, rows[i].x}, rd, err);
      else if (rows[i].op == 3'h1)
      begin
        apb(1'b0, 12'h20c, 32'h0, rd, err);
        chk("prdata", rd, {24'h0, rows[i].e});
      end
      else
        exec_u.run(rows[i].op, rows[i].x, rows[i].y);
      @(negedge i_clk);
      chk("status", status, rows[i].e);
      chk("bank", bank, {rows[i].e[6:5], 7'h00});
    end
    apb(1'b1, 12'h010, 32'hff, rd, err);
    chk("write slverr", err, 1'b1);
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chk("unmapped read", rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, rd, err);
    chk("read slverr", err, 1'b0);
    chk("read after drop", rd, 32'h07);
    @(posedge i_clk);
    i_reset <= 1'b1;
    @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    chk("rereset status", status, 8'h18);
    chk("rereset bank", bank, 9'h000);
    chk("rereset prdata", prdata, 32'h0000_0000);
    chk("rereset pready", {pready, pslverr}, 2'b00);
    close_out();
  end
endmodule
`default_nettype wire
